// >>> hdl/timer_top.v
// two-channel capture/compare timer with APB register access
// assumes: APB master in CLK domain, pin and external clock inputs synchronous to CLK
//
// What this block does
// - Sixteen-bit up-counter, free running or wrapping at a programmable modulo.
// - Counter reads never disturb the count.
// - Three-bit select picks one of seven bus clock rates or external clock.
// - Each channel independently is input capture or output compare.
// - Active capture edge copies the counter into the channel value, flags event.
// - Capture edge selectable rising, falling or either.
// - Counter reaching compare value sets, clears or toggles the pin, flags event.
// - Unbuffered compare value writes take effect immediately.
// - Unsynchronised compare writes may miss compares for up to one period.
// - Channel 0 buffered select links both channels, output on channel 0 pin.
// - Linked pair: last written value pair takes control at each overflow.
// - While linked channel 1 control is ignored and its pin released.
// - Toggle-on-wrap makes the pin toggle when the counter reaches modulo.
// - Positive pulses clear on compare, negative pulses set on compare.
// - Modulo 255 at select 000 gives a 256 bus clock period.
// - Eight-bit PWM width adjustable in 256 steps.
// - Compare flag at pulse end, overflow flag at period end.
// - Overflow flag sets at modulo; clears by read-then-write-zero only.
// - Select value all ones makes external pin the counter clock.
// - Clear without toggle-on-wrap gives 0% duty; clear with toggle-on-wrap and full duty force gives 100%.
// - Mode pair 0:1 unbuffered, 1:0 buffered; edge pair 1:0 clear, 1:1 set.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "timer_regs.vh"

module timer_top (
    // clock and reset
    input wire CLK,
    input wire RESETN,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // external count clock
    input wire EXT_CLK_IN,
    // channel 0 pin
    input wire CH0_IN,
    output wire CH0_OUT,
    output wire CH0_OE_N,
    // channel 1 pin
    input wire CH1_IN,
    output wire CH1_OUT,
    output wire CH1_OE_N
);

    function is_reg;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            is_reg = (addr == ofs);
        end
    endfunction

    // low bits of the prescaler that must all be set for a tick
    function [5:0] ps_mask;
        input [2:0] ps;
        begin
            case (ps)
                3'h0: ps_mask = 6'h00;
                3'h1: ps_mask = 6'h01;
                3'h2: ps_mask = 6'h03;
                3'h3: ps_mask = 6'h07;
                3'h4: ps_mask = 6'h0F;
                3'h5: ps_mask = 6'h1F;
                3'h6: ps_mask = 6'h3F;
                default: ps_mask = 6'h00;
            endcase
        end
    endfunction

    // bus strobes
    wire setup = PSEL & ~PENABLE;
    wire wr = PSEL & PENABLE & PWRITE;
    wire rd = PSEL & PENABLE & ~PWRITE;
    wire hit_sc = is_reg(PADDR, `OFS_STATUS_CONTROL);
    wire hit_cnt = is_reg(PADDR, `OFS_COUNT);
    wire hit_mod = is_reg(PADDR, `OFS_MODULO);
    wire hit_c0sc = is_reg(PADDR, `OFS_CH0_SC);
    wire hit_c0v = is_reg(PADDR, `OFS_CH0_VAL);
    wire hit_c1sc = is_reg(PADDR, `OFS_CH1_SC);
    wire hit_c1v = is_reg(PADDR, `OFS_CH1_VAL);
    wire mapped = hit_sc | hit_cnt | hit_mod | hit_c0sc | hit_c0v | hit_c1sc | hit_c1v;

    reg ovf_flag_q;
    reg ovf_arm_q;
    reg ovf_ie_q;
    reg stop_q;
    reg [2:0] ps_q;
    reg [15:0] mod_q;
    reg [15:0] cnt_q;
    reg [5:0] pre_q;
    reg ext_prev_q;
    reg [6:0] ch0_ctrl_q;
    reg [6:0] ch1_ctrl_q;
    reg [15:0] ch0_val_q;
    reg [15:0] ch1_val_q;
    reg act_q;
    reg last_q;
    reg [31:0] prdata_q;
    reg [31:0] rdata_d;

    wire [5:0] mask = ps_mask(ps_q);
    wire ext_rise = EXT_CLK_IN & ~ext_prev_q;
    wire trst = wr & hit_sc & PWDATA[`SC_RESET];
    wire ext_sel = (ps_q == `PS_EXTERNAL);
    wire pre_tick = ext_sel ? ext_rise : ((pre_q & mask) == mask);
    wire tick = ~stop_q & ~trst & pre_tick;
    wire [15:0] cnt_next = (cnt_q == mod_q) ? 16'h0000 : (cnt_q + 16'h0001);
    wire ovf_ev = tick & (cnt_next == mod_q);

    // linked pair
    wire link = ch0_ctrl_q[`CH_MSB];
    wire [15:0] ch0_cmp = (link && act_q) ? ch1_val_q : ch0_val_q;
    wire [6:0] ch1_eff = link ? 7'h00 : ch1_ctrl_q;

    wire [1:0] ch_in = {CH1_IN, CH0_IN};
    wire [1:0] ch_out;
    wire [1:0] ch_oe_n;
    wire [1:0] ch_flag;
    wire [1:0] ch_cap;
    wire [1:0] sc_rd = {rd & hit_c1sc, rd & hit_c0sc};
    wire [1:0] sc_wr = {wr & hit_c1sc, wr & hit_c0sc};
    wire [6:0] ctrl_w [0:1];
    wire [15:0] cmp_w [0:1];
    assign ctrl_w[0] = ch0_ctrl_q;
    assign ctrl_w[1] = ch1_eff;
    assign cmp_w[0] = ch0_cmp;
    assign cmp_w[1] = ch1_val_q;

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            timer_channel u_ch (
                .clk(CLK),
                .resetn(RESETN),
                .tick(tick),
                .ovf_ev(ovf_ev),
                .cnt_next(cnt_next),
                .cmp_val(cmp_w[i]),
                .ctrl(ctrl_w[i]),
                .sc_rd(sc_rd[i]),
                .sc_wr(sc_wr[i]),
                .wr_flag_bit(PWDATA[`CH_FLAG]),
                .flag(ch_flag[i]),
                .cap_ev(ch_cap[i]),
                .pin_in(ch_in[i]),
                .pin_out(ch_out[i]),
                .pin_oe_n(ch_oe_n[i])
            );
        end
    endgenerate

    // counter, prescaler and overflow flag
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cnt_q <= `RST_COUNT;
            pre_q <= 6'h00;
            ext_prev_q <= 1'b0;
            ovf_flag_q <= 1'b0;
            ovf_arm_q <= 1'b0;
        end else begin
            ext_prev_q <= EXT_CLK_IN;
            if (trst) begin
                cnt_q <= `RST_COUNT;
                pre_q <= 6'h00;
            end else if (!stop_q) begin
                pre_q <= pre_q + 6'h01;
                if (tick) begin
                    cnt_q <= cnt_next;
                end
            end
            // set wins over the clear; an overflow disarms a pending clear
            if (ovf_ev) begin
                ovf_flag_q <= 1'b1;
                ovf_arm_q <= 1'b0;
            end else begin
                if (wr && hit_sc && !PWDATA[`SC_OVF_FLAG] && ovf_arm_q) begin
                    ovf_flag_q <= 1'b0;
                end
                if (wr && hit_sc) begin
                    ovf_arm_q <= 1'b0;
                end else if (rd && hit_sc && ovf_flag_q) begin
                    ovf_arm_q <= 1'b1;
                end
            end
        end
    end

    // control and value registers
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ovf_ie_q <= 1'b0;
            stop_q <= `RST_STOP;
            ps_q <= `RST_PS;
            mod_q <= `RST_MODULO;
            ch0_ctrl_q <= `RST_CH_CTRL;
            ch1_ctrl_q <= `RST_CH_CTRL;
            ch0_val_q <= `RST_CH_VAL;
            ch1_val_q <= `RST_CH_VAL;
        end else begin
            if (wr && hit_sc) begin
                ovf_ie_q <= PWDATA[`SC_OVF_IE];
                stop_q <= PWDATA[`SC_STOP];
                ps_q <= PWDATA[`SC_PS_HI:`SC_PS_LO];
            end
            if (wr && hit_mod) begin
                mod_q <= PWDATA[15:0];
            end
            if (wr && hit_c0sc) begin
                ch0_ctrl_q <= PWDATA[6:0];
            end
            if (wr && hit_c1sc) begin
                ch1_ctrl_q <= PWDATA[6:0];
            end
            // a capture in the same cycle beats a software write
            if (ch_cap[0]) begin
                ch0_val_q <= cnt_q;
            end else if (wr && hit_c0v) begin
                ch0_val_q <= PWDATA[15:0];
            end
            if (ch_cap[1]) begin
                ch1_val_q <= cnt_q;
            end else if (wr && hit_c1v) begin
                ch1_val_q <= PWDATA[15:0];
            end
        end
    end

    // active pair of a linked channel swaps only at overflow
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            act_q <= 1'b0;
            last_q <= 1'b0;
        end else if (!link) begin
            act_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            if (wr && hit_c1v) begin
                last_q <= 1'b1;
            end else if (wr && hit_c0v) begin
                last_q <= 1'b0;
            end
            if (ovf_ev) begin
                act_q <= last_q;
            end
        end
    end

    // read data captured in the setup phase; no read side effect on the count
    always @* begin
        rdata_d = 32'h00000000;
        if (hit_sc) begin
            rdata_d[`SC_OVF_FLAG] = ovf_flag_q;
            rdata_d[`SC_OVF_IE] = ovf_ie_q;
            rdata_d[`SC_STOP] = stop_q;
            rdata_d[`SC_PS_HI:`SC_PS_LO] = ps_q;
        end else if (hit_cnt) begin
            rdata_d[15:0] = cnt_q;
        end else if (hit_mod) begin
            rdata_d[15:0] = mod_q;
        end else if (hit_c0sc) begin
            rdata_d[7:0] = {ch_flag[0], ch0_ctrl_q};
        end else if (hit_c0v) begin
            rdata_d[15:0] = ch0_val_q;
        end else if (hit_c1sc) begin
            rdata_d[7:0] = {ch_flag[1], ch1_ctrl_q};
        end else if (hit_c1v) begin
            rdata_d[15:0] = ch1_val_q;
        end
    end

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            prdata_q <= 32'h00000000;
        end else if (setup && !PWRITE) begin
            prdata_q <= rdata_d;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign CH0_OUT = ch_out[0];
    assign CH0_OE_N = ch_oe_n[0];
    assign CH1_OUT = ch_out[1];
    assign CH1_OE_N = ch_oe_n[1];

endmodule // timer_top

// >>> hdl/timer_regs.vh
// register map, field positions and reset values of the capture/compare timer
// assumes: included by bare name from the timer design files
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// byte offsets on the register bus, one 32-bit word each
`define OFS_STATUS_CONTROL 8'h00
`define OFS_COUNT 8'h04
`define OFS_MODULO 8'h08
`define OFS_CH0_SC 8'h0C
`define OFS_CH0_VAL 8'h10
`define OFS_CH1_SC 8'h14
`define OFS_CH1_VAL 8'h18

// timer_status_control fields
`define SC_OVF_FLAG 7
`define SC_OVF_IE 6
`define SC_STOP 5
`define SC_RESET 4
`define SC_PS_HI 2
`define SC_PS_LO 0
`define PS_EXTERNAL 3'h7

// channel status/control fields
`define CH_FLAG 7
`define CH_IE 6
`define CH_MSB 5
`define CH_MSA 4
`define CH_ELSB 3
`define CH_ELSA 2
`define CH_TOV 1
`define CH_MAX 0

// reset values
`define RST_MODULO 16'hFFFF
`define RST_COUNT 16'h0000
`define RST_STOP 1'b1
`define RST_PS 3'h0
`define RST_CH_CTRL 7'h00
`define RST_CH_VAL 16'h0000

`endif

// >>> hdl/timer_channel.v
// one capture/compare channel: edge capture, compare action, flag, pin
// assumes: tick and ovf_ev are one-cycle pulses from the counter, pins synchronous
`timescale 1ns/1ps
`include "timer_regs.vh"

module timer_channel (
    // clock and reset
    input wire clk,
    input wire resetn,
    // counter events
    input wire tick,
    input wire ovf_ev,
    input wire [15:0] cnt_next,
    input wire [15:0] cmp_val,
    // configuration and flag access
    input wire [6:0] ctrl,
    input wire sc_rd,
    input wire sc_wr,
    input wire wr_flag_bit,
    output wire flag,
    output wire cap_ev,
    // pin
    input wire pin_in,
    output wire pin_out,
    output wire pin_oe_n
);

    wire msb = ctrl[`CH_MSB];
    wire msa = ctrl[`CH_MSA];
    wire elsb = ctrl[`CH_ELSB];
    wire elsa = ctrl[`CH_ELSA];
    wire tov = ctrl[`CH_TOV];
    wire full = ctrl[`CH_MAX] & tov;
    wire els_on = elsb | elsa;
    // buffered select wins over the unbuffered select
    wire oc_mode = els_on & (msb | msa);
    wire ic_mode = els_on & ~msb & ~msa;

    reg pin_prev_q;
    reg flag_q;
    reg arm_q;
    reg out_q;
    reg out_d;

    wire rise = pin_in & ~pin_prev_q;
    wire fall = ~pin_in & pin_prev_q;
    assign cap_ev = ic_mode & ((elsa & rise) | (elsb & fall));
    // match is judged against the value the counter is entering
    wire cmp_ev = oc_mode & tick & (cnt_next == cmp_val);
    wire evt = cap_ev | cmp_ev;

    always @* begin
        out_d = out_q;
        if (!els_on) begin
            out_d = ~msa;
        end else if (oc_mode && ovf_ev && tov) begin
            // overflow beats a compare in the same tick
            out_d = (full & elsb) ? ~elsa : ~out_q;
        end else if (cmp_ev && !full) begin
            case ({elsb, elsa})
                2'b01: out_d = ~out_q;
                2'b10: out_d = 1'b0;
                2'b11: out_d = 1'b1;
                default: out_d = out_q;
            endcase
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_prev_q <= 1'b0;
            flag_q <= 1'b0;
            arm_q <= 1'b0;
            out_q <= 1'b1;
        end else begin
            pin_prev_q <= pin_in;
            out_q <= out_d;
            // a new event always wins over the clear and disarms it
            if (evt) begin
                flag_q <= 1'b1;
                arm_q <= 1'b0;
            end else begin
                if (sc_wr && !wr_flag_bit && arm_q) begin
                    flag_q <= 1'b0;
                end
                if (sc_wr) begin
                    arm_q <= 1'b0;
                end else if (sc_rd && flag_q) begin
                    arm_q <= 1'b1;
                end
            end
        end
    end

    assign flag = flag_q;
    assign pin_out = out_q;
    assign pin_oe_n = ~oc_mode;

endmodule // timer_channel

// >>> bench/timer_board.sv
// board model: channel pin 1 driver, pin 0 pull-up, external count clock
// assumes: tasks are called just after a rising clock edge
`timescale 1ns/1ps

module timer_board (
    // clock
    input wire clk,
    // device pins
    input wire ch0_out,
    input wire ch0_oe_n,
    input wire ch1_out,
    input wire ch1_oe_n,
    // levels seen by the device
    output wire ch0_in,
    output wire ch1_in,
    output logic ext_clk
);
    logic drv1 = 1'b1;
    initial ext_clk = 1'b0;
    // pin 0 is left to its pull-up whenever the device lets go
    assign ch0_in = ch0_oe_n ? 1'b1 : ch0_out;
    assign ch1_in = ch1_oe_n ? drv1 : ch1_out;
    task automatic set_pin1(input logic v);
        drv1 <= v;
        repeat (3) @(posedge clk);
    endtask
    // clock stands still low between bursts
    task automatic ext_pulses(input int n);
        repeat (n) begin
            ext_clk <= 1'b1;
            repeat (2) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule // timer_board

// >>> bench/timer_top_monitor.sv
// checker: bus answers and pin relations of the timer
// assumes: bound to timer_top, channel 0 control shadowed from bus writes
`timescale 1ns/1ps
`include "timer_regs.vh"

module timer_top_monitor (
    // clock and reset
    input wire CLK,
    input wire RESETN,
    // register bus
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    // pins
    input wire CH0_OUT,
    input wire CH0_OE_N,
    input wire CH1_OUT,
    input wire CH1_OE_N
);
    logic [6:0] ch0_q;
    wire unmapped = PADDR > 8'h18 || PADDR[1:0] != 2'h0;
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) ch0_q <= 7'h00;
        else if (PSEL && PENABLE && PWRITE && PADDR == `OFS_CH0_SC) ch0_q <= PWDATA[6:0];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    AST_BUS_ANSWER: assert property (PSEL && PENABLE |-> PREADY && PSLVERR == unmapped)
        else $error("bus access answer wrong");
    AST_UNMAPPED_ZERO: assert property (PSEL && PENABLE && !PWRITE && unmapped |-> PRDATA == 0)
        else $error("unmapped read gave data");
    AST_LINK_FREES_CH1: assert property (ch0_q[5] |-> CH1_OE_N)
        else $error("channel 1 pin driven while linked");
    AST_LINK_CH1_IDLE: assert property (ch0_q[5] [*2] |-> CH1_OUT)
        else $error("channel 1 output moved while linked");
    AST_CAPTURE_RELEASES: assert property (ch0_q[5:4] == 2'h0 |-> CH0_OE_N)
        else $error("capture channel drives its pin");
    AST_COMPARE_DRIVES: assert property (ch0_q[5:4] != 0 && ch0_q[3:2] != 0 |-> !CH0_OE_N)
        else $error("compare channel not driving its pin");
    AST_PRESET_LEVEL: assert property ($stable(ch0_q) && ch0_q[3:2] == 0 |-> CH0_OUT == !ch0_q[4])
        else $error("preset level wrong");
    AST_CLEAR_HOLDS: assert property (ch0_q[5:1] == 5'h0C && !CH0_OUT |=> !CH0_OUT)
        else $error("output left low without overflow toggle");
    AST_SET_HOLDS: assert property (ch0_q[5:1] == 5'h0E && CH0_OUT |=> CH0_OUT)
        else $error("output left high without overflow toggle");
endmodule // timer_top_monitor

bind timer_top timer_top_monitor mon (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CH0_OUT(CH0_OUT), .CH0_OE_N(CH0_OE_N),
    .CH1_OUT(CH1_OUT), .CH1_OE_N(CH1_OE_N));

// >>> bench/timer_top_tb.sv
// testbench: register-level tests of the capture/compare timer
// assumes: timer_top, board model timer_board, checker bound to timer_top
`timescale 1ns/1ps
`include "timer_regs.vh"

module timer_top_tb;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, ext_clk;
    logic ch0_in, ch0_out, ch0_oe_n, ch1_in, ch1_out, ch1_oe_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, c;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    // value address, value, control, high cycles per period; no toggle-on-compare
    logic [35:0] pw [10] = '{36'h10401A041, 36'h10001A001, 36'h10FE1A0FF, 36'h10401E0BF,
        36'h10401B100, 36'h104018000, 36'h10401C100, 36'h10402A041, 36'h18802A081,
        36'h10102A011};
    timer_top uut (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXT_CLK_IN(ext_clk), .CH0_IN(ch0_in), .CH0_OUT(ch0_out),
        .CH0_OE_N(ch0_oe_n), .CH1_IN(ch1_in), .CH1_OUT(ch1_out), .CH1_OE_N(ch1_oe_n));
    timer_board brd (.clk(clk), .ch0_out(ch0_out), .ch0_oe_n(ch0_oe_n), .ch1_out(ch1_out),
        .ch1_oe_n(ch1_oe_n), .ch0_in(ch0_in), .ch1_in(ch1_in), .ext_clk(ext_clk));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim();
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            end_sim();
        end
    end
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never re-drives psel in this time step
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("reg_%h", a), e, q);
    endtask
    // any 256-cycle window of a settled 256-cycle period holds the same high time
    task automatic duty(input logic [31:0] e);
        logic [31:0] h;
        h = 0;
        repeat (512) @(posedge clk);
        repeat (256) begin
            @(negedge clk);
            h = h + ch0_out;
        end
        @(posedge clk);
        cmp("duty_high", e, h);
    endtask
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rc(`OFS_STATUS_CONTROL, 32'h20);
        rc(`OFS_MODULO, 32'hFFFF);
        rc(`OFS_COUNT, 32'h0);
        rc(`OFS_CH0_SC, 32'h0);
        rc(8'h1C, 32'h0);
        apb(1'b1, `OFS_MODULO, 32'h4);
        for (int ps = 0; ps < 7; ps++) begin
            apb(1'b1, `OFS_STATUS_CONTROL, 32'(ps));
            apb(1'b0, `OFS_COUNT, 32'h0);
            c = q;
            // two reads' setup edges lie 4 << ps edges apart: four ticks at any phase
            repeat ((4 << ps) - 3) @(posedge clk);
            rc(`OFS_COUNT, (c + 4) % 5);
        end
        apb(1'b1, `OFS_STATUS_CONTROL, 32'hA0);
        rc(`OFS_STATUS_CONTROL, 32'hA0);
        apb(1'b1, `OFS_STATUS_CONTROL, 32'hA0);
        apb(1'b1, `OFS_STATUS_CONTROL, 32'h20);
        rc(`OFS_STATUS_CONTROL, 32'hA0);
        apb(1'b1, `OFS_STATUS_CONTROL, 32'h20);
        rc(`OFS_STATUS_CONTROL, 32'h20);
        apb(1'b0, `OFS_COUNT, 32'h0);
        c = q;
        apb(1'b1, `OFS_COUNT, 32'h1234);
        rc(`OFS_COUNT, c);
        apb(1'b1, `OFS_STATUS_CONTROL, 32'h30);
        apb(1'b1, `OFS_MODULO, 32'hFF);
        apb(1'b1, `OFS_CH1_SC, 32'h1A);
        apb(1'b1, `OFS_STATUS_CONTROL, 32'h0);
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, pw[i][35:28], {24'h0, pw[i][27:20]});
            if (i == 0 || pw[i][19:12] != pw[i - 1][19:12])
                apb(1'b1, `OFS_CH0_SC, {24'h0, pw[i][19:12]});
            duty({20'h0, pw[i][11:0]});
        end
        apb(1'b1, `OFS_STATUS_CONTROL, 32'h07);
        apb(1'b0, `OFS_COUNT, 32'h0);
        c = q;
        brd.ext_pulses(5);
        rc(`OFS_COUNT, (c + 5) & 32'hFF);
        apb(1'b1, `OFS_STATUS_CONTROL, 32'h20);
        apb(1'b1, `OFS_CH0_SC, 32'h0);
        apb(1'b0, `OFS_COUNT, 32'h0);
        c = q;
        for (int k = 1; k < 4; k++) begin
            apb(1'b1, `OFS_CH1_SC, 32'(k * 4));
            brd.set_pin1(1'b0);
            apb(1'b0, `OFS_CH1_SC, 32'h0);
            apb(1'b1, `OFS_CH1_SC, 32'(k * 4));
            brd.set_pin1(1'b1);
            rc(`OFS_CH1_SC, 32'((k % 2) * 128 + k * 4));
            apb(1'b1, `OFS_CH1_SC, 32'(k * 4));
            brd.set_pin1(1'b0);
            rc(`OFS_CH1_SC, 32'((k / 2) * 128 + k * 4));
        end
        rc(`OFS_CH1_VAL, c);
        end_sim();
    end
endmodule // timer_top_tb
